// ==== tcu_regs.vh ====
`ifndef TCU_REGS_VH
`define TCU_REGS_VH
// ----------------------------------------------------------------------------
// register byte offsets (one aligned word each)
// ----------------------------------------------------------------------------
`define TCU_OFF_MODE 8'h00
`define TCU_OFF_CTRL 8'h04
`define TCU_OFF_IRQEN 8'h08
`define TCU_OFF_STATUS 8'h0c
`define TCU_OFF_IOAB 8'h10
`define TCU_OFF_IOCD 8'h14
`define TCU_OFF_CNT 8'h18
`define TCU_OFF_GRA 8'h1c
`define TCU_OFF_GRB 8'h20
`define TCU_OFF_GRC 8'h24
`define TCU_OFF_GRD 8'h28
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TCU_MODE_RUN 7
`define TCU_MODE_BUFB 5
`define TCU_MODE_BUFA 4
`define TCU_CTRL_COUNTER_CLEAR_ON_MATCH 7
`define TCU_IRQEN_OVF 7
`define TCU_ST_OVF 7
`define TCU_IO_HI_SEL 6
`define TCU_IO_LO_SEL 2
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TCU_CNT_RST 16'h0000
`define TCU_GR_RST 16'hffff
`define TCU_IO_RSVD 8'h88
`define TCU_ST_RSVD 8'h70
`endif

// ==== tcu_top.v ====
`timescale 1ns/1ps
`include "tcu_regs.vh"

// How it works
// - io control bits 7 and 3 read one
// - function select: 0 compare, 1 capture
// - compare action: none, low, high, toggle
// - capture edge: rising, falling, both
// - ab register holds b high, a low
// - 16-bit up-counter, clock select prescaled
// - clear counter on channel a match
// - wrap sets overflow flag, optional irq
// - counter resets to zero
// - compare match sets channel flag
// - match flag raises enabled irq
// - capture latches counter, sets flag
// - capture flag raises enabled irq
// - c buffers a, d buffers b
// - compare match loads buffer into primary
// - capture moves primary into buffer
// - general registers reset to all ones
// - flag cleared by zero after reading one
// - match issued as counter leaves value
module tcu_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] timer_pin_in,
  output wire [3:0] timer_pin_out,
  output wire [3:0] timer_pin_oe,
  input wire ext_count_in,
  output wire irq
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // compare action applied to a pin level
  function pin_next;
    input [1:0] act;
    input cur;
    begin
      case (act)
        2'b01: pin_next = 1'b0;
        2'b10: pin_next = 1'b1;
        2'b11: pin_next = ~cur;
        default: pin_next = cur;
      endcase
    end
  endfunction

  // edge qualifier for capture
  function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      if (sel[1])
        edge_hit = rise | fall;
      else if (sel[0])
        edge_hit = fall;
      else
        edge_hit = rise;
    end
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [7:0] mode_q; // timer_mode_reg: run, buffer enables
  reg [7:0] ctrl_q; // timer_control_reg: clear, clock select
  reg [7:0] irqen_q; // timer_irq_enable_reg
  reg [3:0] flag_q; // match_capture_flag_d..a
  reg ovf_q; // overflow_flag
  reg [4:0] armed_q; // flag read as one, {ovf, d..a}
  reg [5:0] io_ab_q; // io_control_ab writable bits
  reg [5:0] io_cd_q; // io_control_cd writable bits
  reg [15:0] cnt_q; // up_counter
  reg [15:0] gr_q [0:3]; // general_reg_a..d
  reg [3:0] pin_q; // compare outputs
  reg [3:0] sync1_q; // first sync stage
  reg [3:0] sync2_q; // second sync stage
  reg [3:0] prev_q; // previous synced level
  reg [1:0] ext_q; // external clock sync
  reg ext_prev_q; // last external level
  reg [6:0] pre_q; // prescaler
  reg aw_got_q; // write address held
  reg w_got_q; // write data held
  reg [7:0] awaddr_q; // held write address
  reg [31:0] wdata_q; // held write data
  integer i; // loop index for clocked processes
  integer j; // loop index for the event decode

  // --------------------------------------------------------------------------
  // channel configuration
  // --------------------------------------------------------------------------
  wire [3:0] cap_mode; // channel is input capture
  wire [1:0] act [0:3]; // per channel action/edge field
  assign cap_mode = {io_cd_q[5], io_cd_q[2], io_ab_q[5], io_ab_q[2]};
  assign act[0] = io_ab_q[1:0];
  assign act[1] = io_ab_q[4:3];
  assign act[2] = io_cd_q[1:0];
  assign act[3] = io_cd_q[4:3];

  // --------------------------------------------------------------------------
  // counter clock enable
  // --------------------------------------------------------------------------
  reg tick; // one counter increment this cycle
  always @* begin
    case (ctrl_q[2:0])
      3'b000: tick = 1'b1;
      3'b001: tick = (pre_q[1:0] == 2'b11);
      3'b010: tick = (pre_q[2:0] == 3'b111);
      3'b011: tick = (pre_q[4:0] == 5'h1f);
      3'b100: tick = ext_q[1] & ~ext_prev_q;
      default: tick = (pre_q == 7'h7f);
    endcase
    tick = tick & mode_q[`TCU_MODE_RUN];
  end

  // --------------------------------------------------------------------------
  // events
  // --------------------------------------------------------------------------
  wire [3:0] rise = sync2_q & ~prev_q;
  wire [3:0] fall = ~sync2_q & prev_q;
  reg [3:0] match; // compare match this cycle
  reg [3:0] capt; // capture this cycle
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      match[j] = tick & ~cap_mode[j] & (cnt_q == gr_q[j]);
      capt[j] = cap_mode[j] & edge_hit(act[j], rise[j], fall[j]);
    end
  end
  wire wrap = tick & (cnt_q == 16'hffff) & ~(match[0] & ctrl_q[`TCU_CTRL_COUNTER_CLEAR_ON_MATCH]);

  // --------------------------------------------------------------------------
  // axi write path
  // --------------------------------------------------------------------------
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
  wire aw_now = aw_got_q | s_axi_awvalid;
  wire w_now = w_got_q | s_axi_wvalid;
  wire wr_go = aw_now & w_now & ~s_axi_bvalid;
  wire [7:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
  wire wr_mapped = (wa[1:0] == 2'b00) && (wa <= `TCU_OFF_GRD);
  wire [7:0] wsel = wr_go ? wa : 8'hff;

  // --------------------------------------------------------------------------
  // axi read path
  // --------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  reg [31:0] rd_mux; // read data select
  reg rd_ok; // address decodes
  always @* begin
    rd_ok = (s_axi_araddr[1:0] == 2'b00);
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `TCU_OFF_MODE: rd_mux[7:0] = mode_q;
      `TCU_OFF_CTRL: rd_mux[7:0] = ctrl_q;
      `TCU_OFF_IRQEN: rd_mux[7:0] = irqen_q;
      `TCU_OFF_STATUS: rd_mux[7:0] = {ovf_q, 3'b000, flag_q} | `TCU_ST_RSVD;
      `TCU_OFF_IOAB: rd_mux[7:0] = {1'b0, io_ab_q[5:3], 1'b0, io_ab_q[2:0]} | `TCU_IO_RSVD;
      `TCU_OFF_IOCD: rd_mux[7:0] = {1'b0, io_cd_q[5:3], 1'b0, io_cd_q[2:0]} | `TCU_IO_RSVD;
      `TCU_OFF_CNT: rd_mux[15:0] = cnt_q;
      `TCU_OFF_GRA: rd_mux[15:0] = gr_q[0];
      `TCU_OFF_GRB: rd_mux[15:0] = gr_q[1];
      `TCU_OFF_GRC: rd_mux[15:0] = gr_q[2];
      `TCU_OFF_GRD: rd_mux[15:0] = gr_q[3];
      default: rd_ok = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // bus handshake state
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      // capture halves that arrive alone
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      // response once both are in
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // read answer one cycle after address
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin sync and prescaler
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
      ext_q <= 2'b00;
      ext_prev_q <= 1'b0;
      pre_q <= 7'h00;
    end else begin
      sync1_q <= timer_pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      ext_q <= {ext_q[0], ext_count_in};
      ext_prev_q <= ext_q[1];
      pre_q <= pre_q + 7'h01;
    end
  end

  // --------------------------------------------------------------------------
  // control registers and flags
  // --------------------------------------------------------------------------
  wire st_rd = rd_go & (s_axi_araddr == `TCU_OFF_STATUS);
  wire st_wr = (wsel == `TCU_OFF_STATUS) & s_axi_wstrb[0];
  wire [4:0] st_now = {ovf_q, flag_q};
  wire [4:0] st_wv = {wd[`TCU_ST_OVF], wd[3:0]};
  wire [4:0] st_clr = st_wr ? (armed_q & ~st_wv) : 5'h00;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      irqen_q <= 8'h00;
      io_ab_q <= 6'h00;
      io_cd_q <= 6'h00;
      flag_q <= 4'h0;
      ovf_q <= 1'b0;
      armed_q <= 5'h00;
    end else begin
      if ((wsel == `TCU_OFF_MODE) & s_axi_wstrb[0])
        mode_q <= wd[7:0];
      if ((wsel == `TCU_OFF_CTRL) & s_axi_wstrb[0])
        ctrl_q <= wd[7:0];
      if ((wsel == `TCU_OFF_IRQEN) & s_axi_wstrb[0])
        irqen_q <= wd[7:0];
      if ((wsel == `TCU_OFF_IOAB) & s_axi_wstrb[0])
        io_ab_q <= {wd[6:4], wd[2:0]};
      if ((wsel == `TCU_OFF_IOCD) & s_axi_wstrb[0])
        io_cd_q <= {wd[6:4], wd[2:0]};
      // set wins over clear
      flag_q <= (flag_q & ~st_clr[3:0]) | match | capt;
      ovf_q <= (ovf_q & ~st_clr[4]) | wrap;
      // arm on a read that sees one, disarm on a status write
      if (st_rd)
        armed_q <= st_now;
      else if (st_wr)
        armed_q <= 5'h00;
    end
  end

  // --------------------------------------------------------------------------
  // counter, general registers and pins
  // --------------------------------------------------------------------------
  wire cnt_wr = (wsel == `TCU_OFF_CNT) & (&s_axi_wstrb[1:0]);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `TCU_CNT_RST;
      for (i = 0; i < 4; i = i + 1)
        gr_q[i] <= `TCU_GR_RST;
      pin_q <= 4'h0;
    end else begin
      if (cnt_wr)
        cnt_q <= wd[15:0];
      else if (match[0] & ctrl_q[`TCU_CTRL_COUNTER_CLEAR_ON_MATCH])
        cnt_q <= 16'h0000;
      else if (tick)
        cnt_q <= cnt_q + 16'h0001;
      for (i = 0; i < 4; i = i + 1) begin
        if (wsel == (`TCU_OFF_GRA + 8'h04 * i[7:0]) && (&s_axi_wstrb[1:0]))
          gr_q[i] <= wd[15:0];
        if (match[i])
          pin_q[i] <= pin_next(act[i], pin_q[i]);
      end
      // capture and buffer moves, a with c and b with d
      for (i = 0; i < 2; i = i + 1) begin
        if (capt[i]) begin
          gr_q[i] <= cnt_q;
          if (mode_q[`TCU_MODE_BUFA + i])
            gr_q[i + 2] <= gr_q[i];
        end else if (match[i] & mode_q[`TCU_MODE_BUFA + i]) begin
          gr_q[i] <= gr_q[i + 2];
        end
        if (capt[i + 2] & ~mode_q[`TCU_MODE_BUFA + i])
          gr_q[i + 2] <= cnt_q;
      end
    end
  end

  assign timer_pin_out = pin_q;
  assign timer_pin_oe = ~cap_mode;
  assign irq = (|(flag_q & irqen_q[3:0])) | (ovf_q & irqen_q[`TCU_IRQEN_OVF]);

endmodule // tcu_top

// ==== tcu_pin_model.sv ====
`timescale 1ns/1ps
// far side of the timer pins: capture levels in, compare levels out
module tcu_pin_model (
  input wire aclk,
  input wire [3:0] drv,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  output wire [3:0] pin_in
);
  reg [3:0] drv_q = 4'h0; // level the source puts on each pin
  // the source moves its level one edge after it is asked to
  always @(posedge aclk) begin
    drv_q <= drv;
  end
  // wire level: the design where it drives, the source elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_q);
endmodule // tcu_pin_model

// ==== tcu_properties.sv ====
`timescale 1ns/1ps
module tcu_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] timer_pin_out,
  input wire [3:0] timer_pin_oe,
  input wire irq
);
  reg [7:0] ra_q; // address of the read under way
  // keep the read address for judging its answer
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rsvd_ones_a: assert property (
    s_axi_rvalid && s_axi_rresp == 2'b00 && (ra_q == 8'h10 || ra_q == 8'h14) |-> s_axi_rdata[7] && s_axi_rdata[3])
    else $error("reserved io control bits read zero");
  unmapped_a: assert property (s_axi_rvalid && (ra_q > 8'h28 || ra_q[1:0] != 2'b00) |-> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  reset_pins_a: assert property ($past(!aresetn) |-> timer_pin_oe == 4'hf && timer_pin_out == 4'h0 && !irq)
    else $error("pins or irq wrong after reset");
endmodule // tcu_properties
bind tcu_top tcu_properties u_tcu_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .irq(irq));

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "tcu_regs.vh"
module tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg wvalid = 1'b0;
  reg bready = 1'b1; // always ready for the write response
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b1; // always ready for read data
  reg [1:0] bs = 2'b00; // last write response
  reg ext_in = 1'b0;
  reg [3:0] drv = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pin_in, pin_out, pin_oe;
  integer fails = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] rv;
  reg [1:0] rs;
  reg [74:0] rows [0:10]; // write flag, address, data, expected data, expected response
  tcu_top u_tcu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_pin_in(pin_in),
    .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .ext_count_in(ext_in), .irq(irq));
  tcu_pin_model u_tcu_pin_model (.aclk(aclk), .drv(drv), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  always #25 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      conclude;
    end
  end
  // one write; handshakes judged on settled levels, released after the edge
  task wr(input [7:0] a, input [31:0] d);
    reg b;
    reg ah;
    reg wh;
    reg bh;
    begin
      b = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b) begin
        @(negedge aclk);
        ah = awvalid & awready;
        wh = wvalid & wready;
        bh = bvalid & bready;
        if (bh) bs = bresp;
        @(posedge aclk);
        if (ah) awvalid <= 1'b0;
        if (wh) wvalid <= 1'b0;
        if (bh) b = 1'b1;
      end
    end
  endtask
  // one read; data taken while it stands before the accepting edge
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg b;
    reg ah;
    reg rh;
    begin
      b = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!b) begin
        @(negedge aclk);
        ah = arvalid & arready;
        rh = rvalid & rready;
        if (rh) begin
          d = rdata;
          r = rresp;
        end
        @(posedge aclk);
        if (ah) arvalid <= 1'b0;
        if (rh) b = 1'b1;
      end
    end
  endtask
  task chk(input [8*10:1] nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task tend(input [8*10:1] nm);
    $display("test %0s done", nm);
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 4; i = i + 1) rows[i] = {1'b0, 8'h1c + 8'd4 * i[7:0], 32'h0, 32'hffff, 2'b00};
    rows[4] = {1'b0, 8'h18, 32'h0, 32'h0, 2'b00};
    rows[5] = {1'b0, 8'h10, 32'h0, 32'h88, 2'b00};
    rows[6] = {1'b0, 8'h14, 32'h0, 32'h88, 2'b00};
    rows[7] = {1'b1, 8'h10, 32'h77, 32'hff, 2'b00};
    rows[8] = {1'b1, 8'h14, 32'h05, 32'h8d, 2'b00};
    rows[9] = {1'b1, 8'h1c, 32'h1234, 32'h1234, 2'b00};
    rows[10] = {1'b0, 8'h40, 32'h0, 32'h0, 2'b10};
    wait_n(16);
    aresetn <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      if (rows[i][74]) wr(rows[i][73:66], rows[i][65:34]);
      rd(rows[i][73:66], rv, rs);
      chk("reg_data", rv, rows[i][33:2]);
      chk("reg_resp", {30'h0, rs}, {30'h0, rows[i][1:0]});
    end
    // unmapped write is refused with slave error
    wr(8'h40, 32'h0);
    chk("wr_resp", {30'h0, bs}, 32'h2);
    tend("regs");
    // every edge code, counter stopped so the latched value is exact
    for (i = 0; i < 4; i = i + 1) begin
      wr(`TCU_OFF_IOAB, 4 + i);
      wr(`TCU_OFF_CNT, 32'h100 + i);
      wr(`TCU_OFF_GRA, 32'hffff);
      drv <= 4'h1;
      wait_n(8);
      rd(`TCU_OFF_GRA, rv, rs);
      chk("cap_rise", rv, (i == 1) ? 32'hffff : 32'h100 + i);
      wr(`TCU_OFF_GRA, 32'hffff);
      drv <= 4'h0;
      wait_n(8);
      rd(`TCU_OFF_GRA, rv, rs);
      chk("cap_fall", rv, (i == 0) ? 32'hffff : 32'h100 + i);
    end
    // clear only after a read of one, then a buffered capture
    wr(`TCU_OFF_IRQEN, 32'h1);
    wr(`TCU_OFF_STATUS, 32'h0);
    chk("blind_clr", irq, 1);
    rd(`TCU_OFF_STATUS, rv, rs);
    chk("cap_flag", rv[0], 1);
    wr(`TCU_OFF_STATUS, 32'h0);
    chk("clr_flag", irq, 0);
    wr(`TCU_OFF_MODE, 32'h10);
    wr(`TCU_OFF_GRA, 32'h1111);
    wr(`TCU_OFF_CNT, 32'h200);
    drv <= 4'h1;
    wait_n(8);
    chk("cap_irq", irq, 1);
    rd(`TCU_OFF_GRA, rv, rs);
    chk("buf_new", rv, 32'h200);
    rd(`TCU_OFF_GRC, rv, rs);
    chk("buf_old", rv, 32'h1111);
    tend("capture");
    // each compare action on all four pins, one match per pass
    wr(`TCU_OFF_MODE, 32'h0);
    for (i = 0; i < 4; i = i + 1) wr(8'h1c + 8'd4 * i[7:0], 32'h10);
    for (i = 0; i < 4; i = i + 1) begin
      rv = 32'h36 >> (2 * i); // action code of this pass in the low two bits
      wr(`TCU_OFF_IOAB, {26'h0, rv[1:0], 2'b00, rv[1:0]});
      wr(`TCU_OFF_IOCD, {26'h0, rv[1:0], 2'b00, rv[1:0]});
      wr(`TCU_OFF_CNT, 32'h0e);
      wr(`TCU_OFF_MODE, 32'h80);
      wait_n(8);
      wr(`TCU_OFF_MODE, 32'h0);
      chk("pin_level", pin_out, (16'hff0f >> (4 * i)) & 16'hf);
      chk("pin_drive", pin_oe, 4'hf);
    end
    tend("compare");
    // no match flag without a counter tick, then clear on match
    wr(`TCU_OFF_IOAB, 32'h0);
    wr(`TCU_OFF_CTRL, 32'h80);
    wr(`TCU_OFF_GRA, 32'h5);
    wr(`TCU_OFF_CNT, 32'h5);
    rd(`TCU_OFF_STATUS, rv, rs);
    wr(`TCU_OFF_STATUS, 32'h0);
    wait_n(8);
    rd(`TCU_OFF_STATUS, rv, rs);
    chk("no_tick", rv[0], 0);
    wr(`TCU_OFF_MODE, 32'h80);
    wait_n(20);
    wr(`TCU_OFF_MODE, 32'h0);
    rd(`TCU_OFF_STATUS, rv, rs);
    chk("cmp_flag", rv[0], 1);
    chk("cmp_irq", irq, 1);
    rd(`TCU_OFF_CNT, rv, rs);
    chk("cnt_clear", rv <= 32'h5, 1);
    // overflow, with the channel request masked
    wr(`TCU_OFF_CTRL, 32'h0);
    wr(`TCU_OFF_IRQEN, 32'h80);
    chk("irq_mask", irq, 0);
    wr(`TCU_OFF_CNT, 32'hfffe);
    wr(`TCU_OFF_MODE, 32'h80);
    wait_n(4);
    wr(`TCU_OFF_MODE, 32'h0);
    rd(`TCU_OFF_STATUS, rv, rs);
    chk("ovf_flag", rv[7], 1);
    chk("ovf_irq", irq, 1);
    // buffered compare loads the buffer into channel a
    wr(`TCU_OFF_GRC, 32'h9);
    wr(`TCU_OFF_CNT, 32'h3);
    wr(`TCU_OFF_MODE, 32'h90);
    wait_n(4);
    wr(`TCU_OFF_MODE, 32'h0);
    rd(`TCU_OFF_GRA, rv, rs);
    chk("buf_cmp", rv, 32'h9);
    tend("counter");
    // external count source, three rising edges
    wr(`TCU_OFF_CTRL, 32'h4);
    wr(`TCU_OFF_CNT, 32'h0);
    wr(`TCU_OFF_MODE, 32'h80);
    repeat (3) begin
      ext_in <= 1'b1;
      wait_n(3);
      ext_in <= 1'b0;
      wait_n(3);
    end
    wr(`TCU_OFF_MODE, 32'h0);
    rd(`TCU_OFF_CNT, rv, rs);
    chk("ext_count", rv, 32'h3);
    // second reset in mid-run
    aresetn <= 1'b0;
    wait_n(16);
    aresetn <= 1'b1;
    wait_n(1);
    rd(`TCU_OFF_GRA, rv, rs);
    chk("rst_gra", rv, 32'hffff);
    rd(`TCU_OFF_CNT, rv, rs);
    chk("rst_cnt", rv, 32'h0);
    tend("reset");
    conclude;
  end
endmodule // tb_top
